/* File: hdl/tpd_pkg.sv */
// Shared constants and types for the two-port pin data block
package tpd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int BIDIR_W = 16;
  localparam int IN_W    = 8;
  localparam int LANES   = 4;

  // ----------------------------------------------------------------
  // Register map, byte addresses, big-endian lanes
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BIDIR_PORT_DATA_ADDR   = 32'hFFFF_83B0;
  localparam logic [ADDR_W-1:0] BIDIR_PORT_DATA_LO     = 32'hFFFF_83B1;
  localparam logic [ADDR_W-1:0] INPUT_PORT_LEVELS_ADDR = 32'hFFFF_83B3;
  localparam logic [ADDR_W-1:0] WORD_MASK              = 32'hFFFF_FFFC;

  // Lane numbers inside the word at the data register base
  localparam int LANE_DATA_HI = 3;
  localparam int LANE_DATA_LO = 2;
  localparam int LANE_RSVD    = 1;
  localparam int LANE_LEVELS  = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BIDIR_W-1:0] BIDIR_DATA_RESET = 16'h0000;
  localparam logic [DATA_W-1:0]  RDATA_IDLE       = 32'h0000_0000;
  localparam logic [7:0]         RSVD_BYTE        = 8'h00;

  // ----------------------------------------------------------------
  // Access size codes on the size port
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  localparam logic [LANES-1:0] LANES_BYTE = 4'h8;
  localparam logic [LANES-1:0] LANES_WORD = 4'hC;
  localparam logic [LANES-1:0] LANES_LONG = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_NONE, ACC_MAPPED, ACC_BAD} tpd_acc_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        size;
    logic              wr;
    logic              rd;
  } tpd_bus_req_t;

  typedef struct packed {
    logic [BIDIR_W-1:0] dir;
    logic [BIDIR_W-1:0] alt_sel;
    logic [BIDIR_W-1:0] alt_out;
    logic [BIDIR_W-1:0] alt_oe;
  } tpd_pin_ctrl_t;

endpackage

/* File: hdl/tpd_bidir_pin.sv */
// One pin of the bidirectional port: drive select and read view
`timescale 1ns/100ps
module tpd_bidir_pin
  import tpd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Control for this pin
  input  wire logic dir,
  input  wire logic alt_sel,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  // Stored bit and pin level
  input  wire logic data_bit,
  input  wire logic pin_i,
  // Pin drive and read view
  output logic      pin_o_reg,
  output logic      pin_oe_reg,
  output logic      read_bit
);

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  // Direction alone picks the view, alternate use or not
  assign read_bit = dir ? data_bit : pin_i;

  // ----------------------------------------------------------------
  // Drive
  // ----------------------------------------------------------------
  // Stored bit reaches the pin only as an ordinary output
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_o_reg  <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else if (alt_sel) begin
      pin_o_reg  <= alt_out;
      pin_oe_reg <= alt_oe;
    end else begin
      pin_o_reg  <= data_bit;
      pin_oe_reg <= dir;
    end
  end

endmodule

/* File: hdl/tpd_input_port.sv */
// Input-only port: live pin levels with sampling override
`timescale 1ns/100ps
module tpd_input_port
  import tpd_pkg::*;
(
  // Pins and converter state
  input  wire logic [IN_W-1:0] pin_i,
  input  wire logic [IN_W-1:0] adc_sampling,
  // Read view
  output logic      [IN_W-1:0] levels
);

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  // No storage at all, so nothing here to reset
  genvar g;
  generate
    for (g = 0; g < IN_W; g++) begin : g_bit
      assign levels[g] = adc_sampling[g] ? 1'b1 : pin_i[g];
    end
  endgenerate

endmodule

/* File: hdl/tpd_top.sv */
// Top of the two-port pin data block: register port, data store, pins
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps

// Contract
// - Sixteen-pin bidirectional port, data bit fifteen maps to highest pin.
// - Ordinary output pin drives stored bit; read returns stored bit.
// - Ordinary input pin: read returns current pin level.
// - Write to a non-output pin updates store, pin unchanged.
// - Bidirectional data register clears to zero on power-on reset.
// - Watchdog reset, standby and sleep keep the data register.
// - Data register at fixed address, byte, word and long access.
// - Eight-pin input-only port shared with converter inputs, every mode.
// - Input port register read-only at its byte address, live levels.
// - Writes to the input port register are discarded.
// - Pin under converter sampling reads as one.
// - Input port register has no reset value, always live.
module tpd_top
  import tpd_pkg::*;
(
  // Clock and resets
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                wdt_rst,
  // Register port
  input  wire logic [ADDR_W-1:0]   bus_addr,
  input  wire logic [DATA_W-1:0]   bus_wdata,
  input  wire logic [1:0]          bus_size,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [DATA_W-1:0]   bus_rdata_reg,
  output logic                     bus_rvalid_reg,
  output logic                     bus_err_reg,
  // Port control from the pin function logic
  input  wire logic [BIDIR_W-1:0]  bidir_port_direction,
  input  wire logic [BIDIR_W-1:0]  bidir_alt_sel,
  input  wire logic [BIDIR_W-1:0]  bidir_alt_out,
  input  wire logic [BIDIR_W-1:0]  bidir_alt_oe,
  // Bidirectional pins
  input  wire logic [BIDIR_W-1:0]  bidir_pin_i,
  output logic      [BIDIR_W-1:0]  bidir_pin_o_reg,
  output logic      [BIDIR_W-1:0]  bidir_pin_oe_reg,
  output logic      [BIDIR_W-1:0]  bidir_alt_in_reg,
  // Input-only pins and converter
  input  wire logic [IN_W-1:0]     input_pin_i,
  input  wire logic [IN_W-1:0]     adc_sampling,
  output logic      [IN_W-1:0]     analog_channel_input_reg
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Lanes touched by an access; none when misaligned
  function automatic logic [LANES-1:0] lane_enables(
    input logic [1:0] size,
    input logic [1:0] offset
  );
    logic [LANES-1:0] en;
    en = LANES_NONE;
    unique case (size)
      SIZE_BYTE: en = LANES_BYTE >> offset;
      SIZE_WORD: en = offset[0] ? LANES_NONE : (LANES_WORD >> offset);
      SIZE_LONG: en = (offset == 2'h0) ? LANES_LONG : LANES_NONE;
      default:   en = LANES_NONE;
    endcase
    return en;
  endfunction

  // Classify an access from address and lanes
  function automatic tpd_acc_t classify(
    input logic [ADDR_W-1:0] addr,
    input logic [LANES-1:0]  en
  );
    tpd_acc_t acc;
    acc = ACC_BAD;
    if (((addr & WORD_MASK) == BIDIR_PORT_DATA_ADDR) && (en != LANES_NONE)) begin
      acc = ACC_MAPPED;
    end
    return acc;
  endfunction

  // Spread a byte mask over the data bits
  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [LANES-1:0] en
  );
    logic [DATA_W-1:0] m;
    m = RDATA_IDLE;
    for (int i = 0; i < LANES; i++) begin
      m[i*8 +: 8] = {8{en[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  tpd_bus_req_t     req;
  logic [LANES-1:0] req_lanes;
  tpd_acc_t         req_acc;
  logic             wr_hit;
  logic             rd_hit;
  logic             any_req;

  assign req.addr  = bus_addr;
  assign req.wdata = bus_wdata;
  assign req.size  = bus_size;
  assign req.wr    = bus_wr;
  assign req.rd    = bus_rd;

  assign any_req   = req.wr | req.rd;
  assign req_lanes = lane_enables(req.size, req.addr[1:0]);
  assign req_acc   = any_req ? classify(req.addr, req_lanes) : ACC_NONE;
  assign wr_hit    = req.wr && (req_acc == ACC_MAPPED);
  assign rd_hit    = req.rd && (req_acc == ACC_MAPPED);

  // ----------------------------------------------------------------
  // Pin control bundle
  // ----------------------------------------------------------------
  tpd_pin_ctrl_t ctrl;

  assign ctrl.dir     = bidir_port_direction;
  assign ctrl.alt_sel = bidir_alt_sel;
  assign ctrl.alt_out = bidir_alt_out;
  assign ctrl.alt_oe  = bidir_alt_oe;

  // ----------------------------------------------------------------
  // Bidirectional data store
  // ----------------------------------------------------------------
  logic [BIDIR_W-1:0] bidir_port_data_reg;
  logic [BIDIR_W-1:0] bidir_port_data_next;
  logic               wr_hi;
  logic               wr_lo;

  assign wr_hi = wr_hit && req_lanes[LANE_DATA_HI];
  assign wr_lo = wr_hit && req_lanes[LANE_DATA_LO];

  // Stored whatever the pin use; drive is decided per pin
  always_comb begin
    bidir_port_data_next = bidir_port_data_reg;
    if (wr_hi) begin
      bidir_port_data_next[15:8] = req.wdata[LANE_DATA_HI*8 +: 8];
    end
    if (wr_lo) begin
      bidir_port_data_next[7:0] = req.wdata[LANE_DATA_LO*8 +: 8];
    end
  end

  // Only the power-on reset clears it; watchdog reset is left out
  // on purpose, and standby or sleep merely stop the clock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bidir_port_data_reg <= BIDIR_DATA_RESET;
    end else begin
      bidir_port_data_reg <= bidir_port_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Bidirectional pins, bit n on pin n
  // ----------------------------------------------------------------
  logic [BIDIR_W-1:0] bidir_read_view;

  genvar p;
  generate
    for (p = 0; p < BIDIR_W; p++) begin : g_pin
      tpd_bidir_pin u_pin (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .dir        (ctrl.dir[p]),
        .alt_sel    (ctrl.alt_sel[p]),
        .alt_out    (ctrl.alt_out[p]),
        .alt_oe     (ctrl.alt_oe[p]),
        .data_bit   (bidir_port_data_reg[p]),
        .pin_i      (bidir_pin_i[p]),
        .pin_o_reg  (bidir_pin_o_reg[p]),
        .pin_oe_reg (bidir_pin_oe_reg[p]),
        .read_bit   (bidir_read_view[p])
      );
    end
  endgenerate

  // Pin levels handed on to the alternate peripherals
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bidir_alt_in_reg <= BIDIR_DATA_RESET;
    end else begin
      bidir_alt_in_reg <= bidir_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Input-only port
  // ----------------------------------------------------------------
  logic [IN_W-1:0] input_port_levels;

  tpd_input_port u_inport (
    .pin_i        (input_pin_i),
    .adc_sampling (adc_sampling),
    .levels       (input_port_levels)
  );

  // Same pins feed the converter in every mode
  always_ff @(posedge clk_sys) begin
    analog_channel_input_reg <= input_pin_i;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] read_data;

  // Reserved lane reads zero; writes to the levels lane go nowhere
  assign read_word = {bidir_read_view, RSVD_BYTE, input_port_levels};
  assign read_data = read_word & lane_mask(req_lanes);

  // Data stand for exactly one cycle after the read
  always_ff @(posedge clk_sys) begin
    if (sys_rst || wdt_rst) begin
      bus_rdata_reg <= RDATA_IDLE;
    end else if (rd_hit) begin
      bus_rdata_reg <= read_data;
    end else begin
      bus_rdata_reg <= RDATA_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || wdt_rst) begin
      bus_rvalid_reg <= 1'b0;
    end else begin
      bus_rvalid_reg <= req.rd;
    end
  end

  // ----------------------------------------------------------------
  // Access errors
  // ----------------------------------------------------------------
  // Unmapped or misaligned: no effect, reads zero, one-cycle flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst || wdt_rst) begin
      bus_err_reg <= 1'b0;
    end else begin
      bus_err_reg <= (req_acc == ACC_BAD);
    end
  end

endmodule

/* File: bench/tpd_top_properties.sv */
// Port-level checks for the two-port pin data block
`timescale 1ns/100ps
module tpd_top_properties
  import tpd_pkg::*;
(
  // Clock and resets
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic               wdt_rst,
  // Register port
  input wire logic [ADDR_W-1:0]  bus_addr,
  input wire logic [1:0]         bus_size,
  input wire logic               bus_wr,
  input wire logic               bus_rd,
  input wire logic [DATA_W-1:0]  bus_rdata_reg,
  input wire logic               bus_rvalid_reg,
  input wire logic               bus_err_reg,
  // Pins and pin control
  input wire logic [BIDIR_W-1:0] bidir_port_direction,
  input wire logic [BIDIR_W-1:0] bidir_alt_sel,
  input wire logic [BIDIR_W-1:0] bidir_alt_out,
  input wire logic [BIDIR_W-1:0] bidir_alt_oe,
  input wire logic [BIDIR_W-1:0] bidir_pin_i,
  input wire logic [BIDIR_W-1:0] bidir_pin_o_reg,
  input wire logic [BIDIR_W-1:0] bidir_pin_oe_reg,
  input wire logic [BIDIR_W-1:0] bidir_alt_in_reg,
  input wire logic [IN_W-1:0]    input_pin_i,
  input wire logic [IN_W-1:0]    adc_sampling,
  input wire logic [IN_W-1:0]    analog_channel_input_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_lv_rd;
    bus_rd && !wdt_rst && bus_size == SIZE_BYTE && bus_addr == INPUT_PORT_LEVELS_ADDR;
  endsequence
  sequence s_lv_wr;
    bus_wr && !wdt_rst && bus_size == SIZE_BYTE && bus_addr == INPUT_PORT_LEVELS_ADDR;
  endsequence
  // Past values during reset are stale, hence the guards
  property p_oe;
    !$past(sys_rst) |-> bidir_pin_oe_reg ==
      $past((bidir_port_direction & ~bidir_alt_sel) | (bidir_alt_sel & bidir_alt_oe));
  endproperty
  property p_alt_o;
    !$past(sys_rst) |->
      (bidir_pin_o_reg & $past(bidir_alt_sel)) == $past(bidir_alt_out & bidir_alt_sel);
  endproperty
  property p_rst;
    $past(sys_rst) |-> bidir_pin_o_reg == '0 && bidir_pin_oe_reg == '0 && !bus_rvalid_reg;
  endproperty
  property p_rvalid;
    !$past(sys_rst) && !$past(wdt_rst) |-> bus_rvalid_reg == $past(bus_rd);
  endproperty
  property p_idle;
    !bus_rvalid_reg |-> bus_rdata_reg == RDATA_IDLE;
  endproperty
  property p_levels;
    s_lv_rd |=> bus_rdata_reg[7:0] == $past(input_pin_i | adc_sampling) && !bus_err_reg;
  endproperty
  property p_ro_wr;
    s_lv_wr |=> !bus_err_reg;
  endproperty
  // An idle cycle after the refusal lets the flag drop again
  property p_bad_size;
    (bus_wr || bus_rd) && !wdt_rst && bus_size == 2'h3 ##1 !(bus_wr || bus_rd)
      |-> bus_err_reg ##1 !bus_err_reg;
  endproperty
  property p_adc;
    analog_channel_input_reg == $past(input_pin_i);
  endproperty
  property p_alt_in;
    !$past(sys_rst) |-> bidir_alt_in_reg == $past(bidir_pin_i);
  endproperty
  a_oe:       assert property (p_oe)       else $error("pin enable mismatch");
  a_alt_o:    assert property (p_alt_o)    else $error("alternate drive mismatch");
  a_rst:      assert property (p_rst)      else $error("reset state wrong");
  a_rvalid:   assert property (p_rvalid)   else $error("read valid mismatch");
  a_idle:     assert property (p_idle)     else $error("read data not idle");
  a_levels:   assert property (p_levels)   else $error("input levels wrong");
  a_ro_wr:    assert property (p_ro_wr)    else $error("input port write flagged");
  a_bad_size: assert property (p_bad_size) else $error("bad size not refused");
  a_adc:      assert property (p_adc)      else $error("converter path wrong");
  a_alt_in:   assert property (p_alt_in)   else $error("alternate input wrong");
endmodule

/* File: bench/tpd_pin_model.sv */
// Pad model: driven pins follow the block, others the outside level
`timescale 1ns/100ps
module tpd_pin_model
  import tpd_pkg::*;
(
  // Block side and outside level
  input  wire logic [BIDIR_W-1:0] pin_o,
  input  wire logic [BIDIR_W-1:0] pin_oe,
  input  wire logic [BIDIR_W-1:0] ext,
  // Level seen at the pad
  output logic      [BIDIR_W-1:0] pin_i
);
  // Undriven pads show the outside source, never the last driven value
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

/* File: bench/tpd_top_tb.sv */
// Self-checking bench for the two-port pin data block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tpd_top_tb
  import tpd_pkg::*;
;
  logic               clk_sys = 0, sys_rst = 1, wdt_rst = 0, bus_wr = 0, bus_rd = 0;
  logic [ADDR_W-1:0]  bus_addr = '0;
  logic [DATA_W-1:0]  bus_wdata = '0, bus_rdata_reg, d;
  logic [1:0]         bus_size = '0;
  logic               bus_rvalid_reg, bus_err_reg;
  logic [BIDIR_W-1:0] dir = '0, alt_sel = '0, alt_out = '0, alt_oe = '0, ext = '0, st = '0;
  logic [BIDIR_W-1:0] pin_i, pin_o, pin_oe, alt_in;
  logic [IN_W-1:0]    in_pin = '0, adc = '0, an_in;
  int                 miscompares = 0, checks_done = 0, cyc = 0, k;
  logic [ADDR_W-1:0]  wa [4] = '{BIDIR_PORT_DATA_ADDR, BIDIR_PORT_DATA_LO,
                                 BIDIR_PORT_DATA_ADDR, BIDIR_PORT_DATA_ADDR};
  logic [1:0]         ws [4] = '{SIZE_BYTE, SIZE_BYTE, SIZE_WORD, SIZE_LONG};
  always #2.5 clk_sys = ~clk_sys;
  tpd_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .wdt_rst(wdt_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_reg(bus_rdata_reg), .bus_rvalid_reg(bus_rvalid_reg), .bus_err_reg(bus_err_reg),
    .bidir_port_direction(dir), .bidir_alt_sel(alt_sel), .bidir_alt_out(alt_out),
    .bidir_alt_oe(alt_oe), .bidir_pin_i(pin_i), .bidir_pin_o_reg(pin_o),
    .bidir_pin_oe_reg(pin_oe), .bidir_alt_in_reg(alt_in), .input_pin_i(in_pin),
    .adc_sampling(adc), .analog_channel_input_reg(an_in));
  tpd_pin_model pads (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [15:0] e_oe();
    return (dir & ~alt_sel) | (alt_sel & alt_oe);
  endfunction
  function automatic logic [15:0] e_o();
    return (alt_sel & alt_out) | (~alt_sel & st);
  endfunction
  function automatic logic [15:0] e_rd();
    return (dir & st) | (~dir & ((e_oe() & e_o()) | (~e_oe() & ext)));
  endfunction
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One bus cycle, then the answer cycle is checked
  task automatic acc(logic w, r, logic [31:0] a, logic [1:0] s, logic [31:0] wd, ex, logic er);
    @(posedge clk_sys);
    bus_wr <= w; bus_rd <= r; bus_addr <= a; bus_size <= s; bus_wdata <= wd;
    @(posedge clk_sys);
    bus_wr <= 1'b0; bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata_reg, ex)
    `CHK(bus_err_reg, er)
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(74));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    dir <= '1;
    acc(0, 1, BIDIR_PORT_DATA_ADDR, SIZE_WORD, 0, 0, 0);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      k = $urandom_range(3);
      d = $urandom;
      @(posedge clk_sys);
      dir <= 16'($urandom); alt_sel <= 16'($urandom); alt_out <= 16'($urandom);
      alt_oe <= 16'($urandom); ext <= 16'($urandom); in_pin <= 8'($urandom);
      adc <= (i < 4) ? 8'h00 : 8'($urandom);
      acc(1, 0, wa[k], ws[k], d, 0, 0);
      case (k)
        0: st[15:8] = d[31:24];
        1: st[7:0] = d[23:16];
        default: st = d[31:16];
      endcase
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(pin_oe, e_oe())
      `CHK(pin_o, e_o())
      acc(0, 1, BIDIR_PORT_DATA_ADDR, SIZE_WORD, 0, {e_rd(), 16'h0}, 0);
      acc(0, 1, INPUT_PORT_LEVELS_ADDR, SIZE_BYTE, 0, {24'h0, in_pin | adc}, 0);
      acc(0, 1, BIDIR_PORT_DATA_ADDR, SIZE_LONG, 0, {e_rd(), 8'h0, in_pin | adc}, 0);
    end
    $display("test random done");
    acc(1, 0, INPUT_PORT_LEVELS_ADDR, SIZE_BYTE, 32'hFFFF_FFFF, 0, 0);
    @(posedge clk_sys);
    dir <= '1;
    acc(0, 1, BIDIR_PORT_DATA_ADDR, SIZE_WORD, 0, {st, 16'h0}, 0);
    acc(0, 1, 32'hFFFF_83C0, SIZE_BYTE, 0, 0, 1);
    acc(1, 0, BIDIR_PORT_DATA_ADDR, 2'h3, 32'hAAAA_0000, 0, 1);
    acc(0, 1, BIDIR_PORT_DATA_LO, SIZE_WORD, 0, 0, 1);
    $display("test refusals done");
    @(posedge clk_sys);
    wdt_rst <= 1'b1;
    @(posedge clk_sys);
    wdt_rst <= 1'b0;
    acc(0, 1, BIDIR_PORT_DATA_ADDR, SIZE_WORD, 0, {st, 16'h0}, 0);
    // Back to back: write then read with no idle cycle between
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= BIDIR_PORT_DATA_ADDR;
    bus_size <= SIZE_WORD;
    bus_wdata <= 32'h5A5A_0000;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata_reg, 32'h5A5A_0000)
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    acc(0, 1, BIDIR_PORT_DATA_ADDR, SIZE_WORD, 0, 0, 0);
    acc(0, 1, INPUT_PORT_LEVELS_ADDR, SIZE_BYTE, 0, {24'h0, in_pin | adc}, 0);
    $display("test resets done");
    finish_test();
  end
endmodule
bind tpd_top tpd_top_properties u_props (.clk_sys, .sys_rst, .wdt_rst, .bus_addr, .bus_size,
  .bus_wr, .bus_rd, .bus_rdata_reg, .bus_rvalid_reg, .bus_err_reg, .bidir_port_direction,
  .bidir_alt_sel, .bidir_alt_out, .bidir_alt_oe, .bidir_pin_i, .bidir_pin_o_reg,
  .bidir_pin_oe_reg, .bidir_alt_in_reg, .input_pin_i, .adc_sampling, .analog_channel_input_reg);
